// *** hdl/faf_defines.svh ***
// Constants for the flow alarm and feeder unit.
// Assumes inclusion by bare name from the design file.
`ifndef FAF_DEFINES_SVH
`define FAF_DEFINES_SVH
`define FAF_CLK_HZ 10000000
`define FAF_TICK_CYCLES (`FAF_CLK_HZ / 1)
`define FAF_TIMER_MAX 16'd32000
`define FAF_ADR_CTRL 4'h0
`define FAF_ADR_FUNC 4'h1
`define FAF_ADR_SP0 4'h2
`define FAF_ADR_HYS0 4'h6
`define FAF_ADR_PT0 4'ha
`define FAF_ADR_STAT 4'he
`define FAF_ADR_MINMAX 4'hf
`define FAF_FN_OFF 3'h0
`define FAF_FN_OPEN 3'h1
`define FAF_FN_MIN 3'h2
`define FAF_FN_MAX 3'h3
`define FAF_FN_FEED 3'h4
`define FAF_ACT_NONE 2'h0
`define FAF_ACT_TOTCLR 2'h1
`define FAF_ACT_FREEZE 2'h2
`define FAF_ACT_MMCLR 2'h3
`endif

// *** hdl/faf_pkg.sv ***
// Types for the flow alarm and feeder unit.
// Assumes nothing beyond a SystemVerilog compiler.
package faf_pkg;
    typedef enum logic [2:0] {
        FAF_FD_IDLE = 3'b001,
        FAF_FD_RUN = 3'b010,
        FAF_FD_STOP = 3'b100
    } faf_feed_t;
endpackage : faf_pkg

// *** hdl/faf_unit.sv ***
// Alarm channels, min/max tracker and feeder control of a flow panel meter.
// Assumes a synchronous flow reading and raw key/digital inputs from pins.
`timescale 1ns/1ns
`default_nettype none
`include "faf_defines.svh"

// How it works
// - Alarms compare only the instantaneous flow, never the total.
// - Auxiliary current input feeds only the open-sensor alarm.
// - Open-sensor alarm asserts on broken loop, only for current input.
// - Minimum alarm when flow falls below setpoint.
// - Maximum alarm when flow rises above setpoint.
// - Feeder alarm energizes on start, releases when reading reaches setpoint.
// - Each channel holds pulse_time and delay_time, 0 to 32000 seconds.
// - Both timers zero: relay follows alarm directly.
// - Only delay_time set: relay on after alarm lasts delay_time.
// - Only pulse_time set: one pulse of pulse_time seconds.
// - Both set: on pulse_time, off delay_time, repeating during alarm.
// - Indicator lit whenever alarm condition true and not held off by the initial block, regardless of relay.
// - Min and max alarms clear only after reading passes back by hysteresis.
// - Initial block suppresses alarm present at power-up until seen clear.
// - Initial block ignored for open-sensor channels.
// - Lowest and highest flow tracked, both cleared on command.
// - Key and digital input each assignable to one action.
// - Feeder setpoint writes rejected while feeder process active.
// - Trigger from idle starts feeder, energizes feeder relays.
// - Trigger while running freezes process, releases feeder relays.
// - Setpoint reached returns the process to idle and releases; next trigger restarts.
// - Without batch reset on power-up, saved feeder state resumes.
// - Two channels by default, up to four, each with indicator.
module faf_unit #(
    parameter int NCH = 2,
    parameter int TICK_CYCLES = `FAF_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [15:0] flow_i,
    input wire logic loop_broken_i,
    input wire logic function_key_i,
    input wire logic digital_in_i,
    input wire logic power_restored_i,
    input wire logic [1:0] saved_feed_i,
    output logic [NCH-1:0] relay_o,
    output logic [NCH-1:0] indicator_o,
    output logic total_clear_o,
    output logic display_freeze_o,
    output logic feeder_running_o
);
    // Control: [0] current input is flow, [1] key feeds feeder, [2] din feeds feeder,
    // [4:3] key action, [6:5] din action, [7] batch_reset_on_power_up, [15:8] init block
    logic [15:0] ctrl_r;
    logic [3*NCH-1:0] func_r;
    logic [15:0] sp_r [NCH];
    logic [15:0] hys_r [NCH];
    logic [15:0] pulse_time_r [NCH];
    logic [15:0] delay_time_r [NCH];
    logic [15:0] fmin_r, fmax_r;
    logic wb_ack_r;
    logic wr_stb, mm_clr_cmd;
    logic [1:0] key_s_r, din_s_r;
    logic key_q_r, din_q_r, key_trig, din_trig, feed_trig;
    logic [31:0] tick_cnt_r;
    logic tick;
    faf_pkg::faf_feed_t feed_r;
    logic [NCH-1:0] alarm_r, armed_r, feed_done;

    // Single-cycle ack; drops the cycle after it is given
    // Write lands at the edge where the master samples ack high
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_r <= 1'b0;
        end else begin
            wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
        end
    end
    assign wb_ack_o = wb_ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 16'h0000;
            func_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                sp_r[i] <= 16'h0000;
                hys_r[i] <= 16'h0000;
                pulse_time_r[i] <= 16'h0000;
                delay_time_r[i] <= 16'h0000;
            end
        end else if (wr_stb && wb_sel_i[0]) begin
            if (wb_adr_i == `FAF_ADR_CTRL) begin
                ctrl_r <= wb_dat_i[15:0];
            end
            if (wb_adr_i == `FAF_ADR_FUNC) begin
                func_r <= wb_dat_i[3*NCH-1:0];
            end
            for (int i = 0; i < NCH; i++) begin
                // Feeder setpoint locked while a process is active
                if (wb_adr_i == `FAF_ADR_SP0 + 4'(i) &&
                    !(func_r[3*i+:3] == `FAF_FN_FEED && feed_r != faf_pkg::FAF_FD_IDLE)) begin
                    sp_r[i] <= wb_dat_i[15:0];
                end
                if (wb_adr_i == `FAF_ADR_HYS0 + 4'(i)) begin
                    hys_r[i] <= wb_dat_i[15:0];
                end
                if (wb_adr_i == `FAF_ADR_PT0 + 4'(i)) begin
                    // Clamped to the 32000 s ceiling
                    pulse_time_r[i] <= (wb_dat_i[15:0] > `FAF_TIMER_MAX) ?
                        `FAF_TIMER_MAX : wb_dat_i[15:0];
                    delay_time_r[i] <= (wb_dat_i[31:16] > `FAF_TIMER_MAX) ?
                        `FAF_TIMER_MAX : wb_dat_i[31:16];
                end
            end
        end
    end

    always_comb begin
        wb_dat_o = 32'h0000_0000;
        if (wb_ack_r) begin
            case (wb_adr_i)
                `FAF_ADR_CTRL: wb_dat_o = {16'h0000, ctrl_r};
                `FAF_ADR_FUNC: wb_dat_o = 32'(func_r);
                `FAF_ADR_STAT: wb_dat_o = {24'h000000, 5'(feed_r), 3'h0} |
                    (32'({alarm_r, relay_o}) << 8);
                `FAF_ADR_MINMAX: wb_dat_o = {fmax_r, fmin_r};
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (wb_adr_i == `FAF_ADR_SP0 + 4'(i)) wb_dat_o = {16'h0000, sp_r[i]};
                        if (wb_adr_i == `FAF_ADR_HYS0 + 4'(i)) wb_dat_o = {16'h0000, hys_r[i]};
                        if (wb_adr_i == `FAF_ADR_PT0 + 4'(i)) begin
                            wb_dat_o = {delay_time_r[i], pulse_time_r[i]};
                        end
                    end
                end
            endcase
        end
    end

    // Pin inputs pass two flops before edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_s_r <= 2'b00;
            din_s_r <= 2'b00;
            key_q_r <= 1'b0;
            din_q_r <= 1'b0;
        end else begin
            key_s_r <= {key_s_r[0], function_key_i};
            din_s_r <= {din_s_r[0], digital_in_i};
            key_q_r <= key_s_r[1];
            din_q_r <= din_s_r[1];
        end
    end
    assign key_trig = key_s_r[1] && !key_q_r;
    assign din_trig = din_s_r[1] && !din_q_r;
    // Feeder flag overrides the action field for that source
    assign feed_trig = (key_trig && ctrl_r[1]) || (din_trig && ctrl_r[2]);
    assign mm_clr_cmd = (key_trig && !ctrl_r[1] && ctrl_r[4:3] == `FAF_ACT_MMCLR) ||
        (din_trig && !ctrl_r[2] && ctrl_r[6:5] == `FAF_ACT_MMCLR);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            total_clear_o <= 1'b0;
            display_freeze_o <= 1'b0;
        end else begin
            total_clear_o <= (key_trig && !ctrl_r[1] && ctrl_r[4:3] == `FAF_ACT_TOTCLR) ||
                (din_trig && !ctrl_r[2] && ctrl_r[6:5] == `FAF_ACT_TOTCLR);
            if ((key_trig && !ctrl_r[1] && ctrl_r[4:3] == `FAF_ACT_FREEZE) ||
                (din_trig && !ctrl_r[2] && ctrl_r[6:5] == `FAF_ACT_FREEZE)) begin
                display_freeze_o <= !display_freeze_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || mm_clr_cmd) begin
            fmin_r <= 16'hffff;
            fmax_r <= 16'h0000;
        end else if (ctrl_r[0]) begin
            if (flow_i < fmin_r) fmin_r <= flow_i;
            if (flow_i > fmax_r) fmax_r <= flow_i;
        end
    end

    // Whole-second tick for every channel at once
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    // Feeder process; power-up restore honoured only without batch reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feed_r <= faf_pkg::FAF_FD_IDLE;
        end else if (power_restored_i) begin
            if (ctrl_r[7]) feed_r <= faf_pkg::FAF_FD_IDLE;
            else if (saved_feed_i == 2'h1) feed_r <= faf_pkg::FAF_FD_RUN;
            else if (saved_feed_i == 2'h2) feed_r <= faf_pkg::FAF_FD_STOP;
            else feed_r <= faf_pkg::FAF_FD_IDLE;
        end else begin
            case (feed_r)
                faf_pkg::FAF_FD_IDLE: if (feed_trig) feed_r <= faf_pkg::FAF_FD_RUN;
                faf_pkg::FAF_FD_RUN: begin
                    if (feed_trig) feed_r <= faf_pkg::FAF_FD_STOP;
                    else if (|feed_done) feed_r <= faf_pkg::FAF_FD_IDLE;
                end
                faf_pkg::FAF_FD_STOP: if (feed_trig) feed_r <= faf_pkg::FAF_FD_RUN;
                default: feed_r <= faf_pkg::FAF_FD_IDLE;
            endcase
        end
    end
    assign feeder_running_o = (feed_r == faf_pkg::FAF_FD_RUN);

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic [2:0] fn;
        logic src_ok, raw, cond;
        logic [16:0] sp_hi, sp_lo;
        logic [15:0] cnt_r;
        logic phase_r, out_r, fired_r;
        assign fn = func_r[3*g+:3];
        assign sp_hi = {1'b0, sp_r[g]} + {1'b0, hys_r[g]};
        assign sp_lo = {1'b0, sp_r[g]} - {1'b0, hys_r[g]};
        assign feed_done[g] = (fn == `FAF_FN_FEED) && ({1'b0, flow_i} >= {1'b0, sp_r[g]});
        // Flow comparisons need the current input as flow source
        assign src_ok = ctrl_r[0] || fn == `FAF_FN_OPEN;
        always_comb begin
            raw = 1'b0;
            case (fn)
                `FAF_FN_OPEN: raw = loop_broken_i && !ctrl_r[0];
                `FAF_FN_MIN: raw = alarm_r[g] ? ({1'b0, flow_i} < sp_hi) :
                    (flow_i < sp_r[g]);
                `FAF_FN_MAX: raw = alarm_r[g] ? ({1'b0, flow_i} > sp_lo) || sp_lo[16] :
                    (flow_i > sp_r[g]);
                `FAF_FN_FEED: raw = feed_r == faf_pkg::FAF_FD_RUN && !feed_done[g];
                default: raw = 1'b0;
            endcase
        end
        assign cond = raw && src_ok;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                alarm_r[g] <= 1'b0;
                armed_r[g] <= 1'b0;
            end else begin
                // An unconfigured channel after power-up does not arm itself
                if ((!cond && fn != `FAF_FN_OFF) || fn == `FAF_FN_OPEN) begin
                    armed_r[g] <= 1'b1;
                end
                alarm_r[g] <= cond && (armed_r[g] || !ctrl_r[8+g] ||
                    fn == `FAF_FN_OPEN);
            end
        end
        assign indicator_o[g] = alarm_r[g];
        // Timer stage: cnt counts seconds within the current phase
        always_ff @(posedge clk_i) begin
            if (rst_i || !alarm_r[g]) begin
                cnt_r <= 16'h0;
                phase_r <= 1'b0;
                out_r <= 1'b0;
                fired_r <= 1'b0;
            end else if (pulse_time_r[g] == 16'h0 && delay_time_r[g] == 16'h0) begin
                out_r <= 1'b1;
            end else if (pulse_time_r[g] == 16'h0) begin
                if (tick && cnt_r < delay_time_r[g]) cnt_r <= cnt_r + 16'h1;
                out_r <= (cnt_r >= delay_time_r[g]);
            end else if (delay_time_r[g] == 16'h0) begin
                // Drop with the last tick so the relay never outlasts the pulse
                out_r <= !(fired_r || (tick && cnt_r + 16'h1 >= pulse_time_r[g]));
                if (tick) cnt_r <= cnt_r + 16'h1;
                if (tick && cnt_r + 16'h1 >= pulse_time_r[g]) fired_r <= 1'b1;
            end else begin
                out_r <= !phase_r;
                if (tick) begin
                    if (cnt_r + 16'h1 >= (phase_r ? delay_time_r[g] : pulse_time_r[g])) begin
                        cnt_r <= 16'h0;
                        phase_r <= !phase_r;
                    end else begin
                        cnt_r <= cnt_r + 16'h1;
                    end
                end
            end
        end
        assign relay_o[g] = out_r && alarm_r[g];

        rly_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
            alarm_r[g] && pulse_time_r[g] == 16'h0 && delay_time_r[g] == 16'h0
            && $stable(alarm_r[g]) |-> relay_o[g])
            else $error("relay not following alarm");
        rly_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
            !alarm_r[g] |-> !relay_o[g])
            else $error("relay on without alarm");
        dly_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
            pulse_time_r[g] == 16'h0 && delay_time_r[g] != 16'h0 && cnt_r < delay_time_r[g]
            |-> !relay_o[g])
            else $error("delay relay early");
        pls_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
            fired_r && delay_time_r[g] == 16'h0 |-> !relay_o[g])
            else $error("pulse outlasted");
        opn_flow_a: assert property (@(posedge clk_i) disable iff (rst_i)
            fn == `FAF_FN_OPEN && ctrl_r[0] |=> !alarm_r[g])
            else $error("open alarm with flow input");
        osc_cv: cover property (@(posedge clk_i) relay_o[g] ##[1:1000] !relay_o[g] && alarm_r[g]);
    end

    fd_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        feed_r == faf_pkg::FAF_FD_IDLE && feed_trig && !power_restored_i
        |=> feed_r == faf_pkg::FAF_FD_RUN)
        else $error("feeder did not start");
    fd_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        feed_r == faf_pkg::FAF_FD_RUN && feed_trig && !power_restored_i
        |=> feed_r == faf_pkg::FAF_FD_STOP)
        else $error("feeder did not freeze");
    sp_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        func_r[2:0] == `FAF_FN_FEED && feed_r != faf_pkg::FAF_FD_IDLE |=> $stable(sp_r[0]))
        else $error("feeder setpoint changed");
    mm_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mm_clr_cmd |=> fmin_r == 16'hffff && fmax_r == 16'h0000)
        else $error("min max not cleared");
    fd_run_cv: cover property (@(posedge clk_i) feed_r == faf_pkg::FAF_FD_RUN);
    fd_done_cv: cover property (@(posedge clk_i)
        feed_r == faf_pkg::FAF_FD_RUN ##1 feed_r == faf_pkg::FAF_FD_IDLE);
    mm_clr_cv: cover property (@(posedge clk_i) mm_clr_cmd);
endmodule : faf_unit
`default_nettype wire

// *** tb/faf_field_model.sv ***
// Far side of the flow alarm unit: flow sensor, current loop, key and digital input.
// Assumes the bench calls its tasks from a process synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module faf_field_model (
    input wire logic clk_i,
    output logic [15:0] flow_o,
    output logic loop_broken_o,
    output logic key_o,
    output logic din_o
);
    initial begin
        flow_o = 16'h0000;
        loop_broken_o = 1'b0;
        key_o = 1'b0;
        din_o = 1'b0;
    end
    task automatic set_flow(input logic [15:0] v);
        @(posedge clk_i);
        flow_o <= v;
    endtask : set_flow
    task automatic set_loop(input logic v);
        @(posedge clk_i);
        loop_broken_o <= v;
    endtask : set_loop
    // Held and then left quiet long enough for the input synchroniser
    task automatic press(input logic use_din);
        @(posedge clk_i);
        if (use_din) begin
            din_o <= 1'b1;
        end else begin
            key_o <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
        key_o <= 1'b0;
        din_o <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask : press
endmodule : faf_field_model
`default_nettype wire

// *** tb/faf_unit_tb.sv ***
// Self-checking bench for the flow alarm and feeder unit.
// Assumes a one-cycle Wishbone answer and a short tick parameter.
`timescale 1ns/1ns
`default_nettype none
`include "faf_defines.svh"
module faf_unit_tb;
    localparam int TICK = 10;
    logic clk_i = 1'b0;
    logic rst_i;
    logic [3:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_we_i;
    logic [3:0] wb_sel_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_ack_o;
    logic [15:0] flow_i;
    logic loop_broken_i, function_key_i, digital_in_i;
    logic power_restored_i;
    logic [1:0] saved_feed_i;
    logic prev_relay;
    logic [1:0] relay_o, indicator_o;
    logic total_clear_o, display_freeze_o, feeder_running_o;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int clears = 0;
    int n;
    logic [31:0] rdata;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    faf_unit #(.NCH(2), .TICK_CYCLES(TICK)) i_faf_unit (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .flow_i(flow_i), .loop_broken_i(loop_broken_i), .function_key_i(function_key_i),
        .digital_in_i(digital_in_i), .power_restored_i(power_restored_i),
        .saved_feed_i(saved_feed_i), .relay_o(relay_o), .indicator_o(indicator_o),
        .total_clear_o(total_clear_o), .display_freeze_o(display_freeze_o),
        .feeder_running_o(feeder_running_o));
    faf_field_model i_faf_field_model (.clk_i(clk_i), .flow_o(flow_i),
        .loop_broken_o(loop_broken_i), .key_o(function_key_i), .din_o(digital_in_i));
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Generous ceiling: the whole sequence needs about 500 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (total_clear_o === 1'b1) begin
            clears <= clears + 1;
        end
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected timeout: expected %0d, seen %0d", 0, cycles);
            tally_and_finish();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'hf;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [3:0] adr, input logic [31:0] exp, input string name);
        wb(1'b0, adr, 32'h0);
        chk(name, exp, rdata);
    endtask : rd
    // Outputs packed as {indicator, relay} for a compact compare
    task automatic flow_chk(input logic [15:0] v, input logic [3:0] exp);
        i_faf_field_model.set_flow(v);
        repeat (3) @(posedge clk_i);
        chk("indicator and relay", {28'h0, exp}, {28'h0, indicator_o, relay_o});
    endtask : flow_chk
    task automatic wait_relay(input logic v, input int lim, input string name);
        n = 0;
        while (relay_o[0] !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk(name, {31'h0, v}, {31'h0, relay_o[0]});
    endtask : wait_relay
    task automatic feed_chk(input logic exp);
        chk("feeder running", {31'h0, exp}, {31'h0, feeder_running_o});
        chk("feeder relay", {31'h0, exp}, {31'h0, relay_o[0]});
    endtask : feed_chk
    task automatic test_limits;
        wb(1'b1, `FAF_ADR_CTRL, 32'h1);
        wb(1'b1, `FAF_ADR_FUNC, 32'h13);
        wb(1'b1, `FAF_ADR_SP0, 32'd100);
        wb(1'b1, 4'h3, 32'd50);
        wb(1'b1, `FAF_ADR_HYS0, 32'd10);
        wb(1'b1, 4'h7, 32'd10);
        flow_chk(16'd120, 4'b0101);
        flow_chk(16'd95, 4'b0101);
        flow_chk(16'd90, 4'b0000);
        flow_chk(16'd40, 4'b1010);
        flow_chk(16'd55, 4'b1010);
        flow_chk(16'd60, 4'b0000);
    endtask : test_limits
    task automatic test_timers;
        wb(1'b1, `FAF_ADR_FUNC, 32'h3);
        wb(1'b1, `FAF_ADR_PT0, 32'hffffffff);
        rd(`FAF_ADR_PT0, 32'h7d007d00, "timer clamp");
        wb(1'b1, `FAF_ADR_PT0, {16'd3, 16'd0});
        flow_chk(16'd120, 4'b0100);
        repeat (12) @(posedge clk_i);
        chk("delayed relay", 32'h2, {30'h0, indicator_o[0], relay_o[0]});
        wait_relay(1'b1, 50, "delay relay");
        flow_chk(16'd0, 4'b0000);
        wb(1'b1, `FAF_ADR_PT0, {16'd0, 16'd2});
        i_faf_field_model.set_flow(16'd120);
        wait_relay(1'b1, 15, "pulse start");
        wait_relay(1'b0, 40, "pulse end");
        repeat (40) @(posedge clk_i);
        chk("single pulse", 32'h2, {30'h0, indicator_o[0], relay_o[0]});
        flow_chk(16'd0, 4'b0000);
        wb(1'b1, `FAF_ADR_PT0, {16'd1, 16'd1});
        i_faf_field_model.set_flow(16'd120);
        n = 0;
        prev_relay = relay_o[0];
        repeat (100) begin
            @(posedge clk_i);
            n += (relay_o[0] === 1'b1 && prev_relay === 1'b0) ? 1 : 0;
            prev_relay = relay_o[0];
        end
        chk("oscillator rises", 32'h1, {31'h0, n >= 3});
        flow_chk(16'd0, 4'b0000);
        wb(1'b1, `FAF_ADR_PT0, 32'h0);
    endtask : test_timers
    task automatic test_open;
        wb(1'b1, `FAF_ADR_CTRL, 32'h0);
        wb(1'b1, `FAF_ADR_FUNC, 32'h11);
        i_faf_field_model.set_loop(1'b1);
        flow_chk(16'd0, 4'b0101);
        i_faf_field_model.set_loop(1'b0);
        flow_chk(16'd0, 4'b0000);
    endtask : test_open
    task automatic test_keys;
        wb(1'b1, `FAF_ADR_FUNC, 32'h0);
        wb(1'b1, `FAF_ADR_CTRL, 32'h39);
        i_faf_field_model.set_flow(16'd70);
        i_faf_field_model.press(1'b0);
        flow_chk(16'd40, 4'b0000);
        rd(`FAF_ADR_MINMAX, {16'd70, 16'd40}, "min and max");
        n = clears;
        i_faf_field_model.press(1'b1);
        chk("total clears", 32'h1, clears - n);
        wb(1'b1, `FAF_ADR_CTRL, 32'h11);
        i_faf_field_model.press(1'b0);
        chk("freeze", 32'h1, {31'h0, display_freeze_o});
        i_faf_field_model.press(1'b0);
        chk("unfreeze", 32'h0, {31'h0, display_freeze_o});
    endtask : test_keys
    task automatic test_feeder;
        wb(1'b1, `FAF_ADR_CTRL, 32'h3);
        wb(1'b1, `FAF_ADR_FUNC, 32'h4);
        wb(1'b1, `FAF_ADR_SP0, 32'd500);
        i_faf_field_model.set_flow(16'd100);
        i_faf_field_model.press(1'b0);
        feed_chk(1'b1);
        wb(1'b1, `FAF_ADR_SP0, 32'd600);
        rd(`FAF_ADR_SP0, 32'd500, "locked setpoint");
        i_faf_field_model.press(1'b0);
        feed_chk(1'b0);
        wb(1'b0, `FAF_ADR_STAT, 32'h0);
        chk("stopped state", 32'h4, {29'h0, rdata[5:3]});
        i_faf_field_model.press(1'b0);
        feed_chk(1'b1);
        i_faf_field_model.set_flow(16'd500);
        repeat (3) @(posedge clk_i);
        feed_chk(1'b0);
        wb(1'b1, `FAF_ADR_SP0, 32'd600);
        rd(`FAF_ADR_SP0, 32'd600, "free setpoint");
    endtask : test_feeder
    task automatic restore(input logic [1:0] st);
        @(posedge clk_i);
        saved_feed_i <= st;
        power_restored_i <= 1'b1;
        @(posedge clk_i);
        power_restored_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : restore
    task automatic test_block;
        i_faf_field_model.set_flow(16'd120);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, `FAF_ADR_CTRL, 32'h101);
        wb(1'b1, `FAF_ADR_SP0, 32'd100);
        wb(1'b1, `FAF_ADR_FUNC, 32'h3);
        flow_chk(16'd120, 4'b0000);
        flow_chk(16'd0, 4'b0000);
        flow_chk(16'd120, 4'b0101);
        wb(1'b1, `FAF_ADR_CTRL, 32'h81);
        restore(2'h1);
        chk("batch reset", 32'h0, {31'h0, feeder_running_o});
    endtask : test_block
    initial begin
        rst_i = 1'b1;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        power_restored_i = 1'b0;
        saved_feed_i = 2'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`FAF_ADR_STAT, 32'h8, "status after reset");
        chk("idle read data", 32'h0, wb_dat_o);
        test_limits();
        test_timers();
        test_open();
        test_keys();
        test_feeder();
        // Flow below setpoint so the restored run is not ended at once
        i_faf_field_model.set_flow(16'd100);
        restore(2'h1);
        feed_chk(1'b1);
        restore(2'h2);
        feed_chk(1'b0);
        wb(1'b0, `FAF_ADR_STAT, 32'h0);
        chk("restored stop", 32'h4, {29'h0, rdata[5:3]});
        test_block();
        tally_and_finish();
    end
endmodule : faf_unit_tb
`default_nettype wire
